//--- hdl/core_map.svh
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH
// ****************************************
// instruction timing
// ****************************************
`define CYC_PER_INSTR 4
`define PHASE_LAST    2'h3
`define RST_PHASE     2'h0
// ****************************************
// data memory locations with side effects
// ****************************************
`define ADDR_PC_LO    7'h02
`define ADDR_TBLP     7'h03
`define ADDR_TBLH     7'h04
// ****************************************
// table region and reset values
// ****************************************
`define TBL_PAGE      3'h7
`define RST_PC        11'h000
`define RST_ACC       8'h00
// ****************************************
// instruction word fields
// ****************************************
`define F_OP_HI       15
`define F_OP_LO       11
`define F_DEST        10
`define F_BIT_HI      9
`define F_BIT_LO      7
`define F_MEM_HI      6
`define F_ADDR_HI     10
`define F_IMM_HI      7
`endif

//--- hdl/core_pkg.sv
package core_pkg;
  // ****************************************
  // opcodes of the 16-bit instruction word
  // ****************************************
  typedef enum logic [4:0] {
    OP_NOP    = 5'b00000, OP_ADD_M  = 5'b00001, OP_ADD_X  = 5'b00010,
    OP_SUB_M  = 5'b00011, OP_SUB_X  = 5'b00100, OP_AND_M  = 5'b00101,
    OP_OR_M   = 5'b00110, OP_XOR_M  = 5'b00111, OP_BITINV = 5'b01000,
    OP_INC    = 5'b01001, OP_DEC    = 5'b01010, OP_ROTR   = 5'b01011,
    OP_ROTL   = 5'b01100, OP_ROTRC  = 5'b01101, OP_ROTLC  = 5'b01110,
    OP_XFER_MA= 5'b01111, OP_XFER_AM= 5'b10000, OP_XFER_X = 5'b10001,
    OP_BITSET = 5'b10010, OP_BITZERO= 5'b10011, OP_UJUMP  = 5'b10100,
    OP_CALL   = 5'b10101, OP_SUBEXIT= 5'b10110, OP_INTEXIT= 5'b10111,
    OP_SKZ    = 5'b11000, OP_SKBZ   = 5'b11001, OP_SKBNZ  = 5'b11010,
    OP_SKINC  = 5'b11011, OP_SKDEC  = 5'b11100, OP_TABRD  = 5'b11101,
    OP_PWRDN  = 5'b11110, OP_WDTCLR = 5'b11111
  } op_t;
  // ****************************************
  // alu functions
  // ****************************************
  typedef enum logic [3:0] {
    ALU_ADD  = 4'b0000, ALU_SUB  = 4'b0001, ALU_AND  = 4'b0010,
    ALU_OR   = 4'b0011, ALU_XOR  = 4'b0100, ALU_INV  = 4'b0101,
    ALU_INC  = 4'b0110, ALU_DEC  = 4'b0111, ALU_ROR  = 4'b1000,
    ALU_ROL  = 4'b1001, ALU_RORC = 4'b1010, ALU_ROLC = 4'b1011,
    ALU_PASSA= 4'b1100, ALU_PASSB= 4'b1101, ALU_SETB = 4'b1110,
    ALU_CLRB = 4'b1111
  } alu_op_t;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00, ST_FLUSH = 2'b01, ST_TBL = 2'b10, ST_SLEEP = 2'b11
  } state_t;
endpackage

//--- hdl/alu_if.sv
// ****************************************
// core to alu operand and result bundle
// ****************************************
interface alu_if;
  core_pkg::alu_op_t op;
  logic [7:0]        a;
  logic [7:0]        b;
  logic              cin;
  logic [2:0]        bsel;
  logic [7:0]        res;
  logic              cout;
  logic              zero;
  modport core (output op, a, b, cin, bsel, input res, cout, zero);
  modport alu  (input op, a, b, cin, bsel, output res, cout, zero);
endinterface

//--- hdl/alu_unit.sv
module alu_unit (
  alu_if.alu bus
);
  // ****************************************
  // single bit mask
  // ****************************************
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  // eight-bit result, carry out
  always_comb begin
    bus.cout = bus.cin;
    bus.res  = bus.b;
    case (bus.op)
      core_pkg::ALU_ADD:  {bus.cout, bus.res} = {1'b0, bus.a} + {1'b0, bus.b};
      core_pkg::ALU_SUB:  {bus.cout, bus.res} = {1'b0, bus.a} - {1'b0, bus.b};
      core_pkg::ALU_AND:  bus.res = bus.a & bus.b;
      core_pkg::ALU_OR:   bus.res = bus.a | bus.b;
      core_pkg::ALU_XOR:  bus.res = bus.a ^ bus.b;
      core_pkg::ALU_INV:  bus.res = ~bus.b;
      core_pkg::ALU_INC:  bus.res = bus.b + 8'h01;
      core_pkg::ALU_DEC:  bus.res = bus.b - 8'h01;
      core_pkg::ALU_ROR:  bus.res = {bus.b[0], bus.b[7:1]};
      core_pkg::ALU_ROL:  bus.res = {bus.b[6:0], bus.b[7]};
      core_pkg::ALU_RORC: begin
        bus.res  = {bus.cin, bus.b[7:1]};
        bus.cout = bus.b[0];
      end
      core_pkg::ALU_ROLC: begin
        bus.res  = {bus.b[6:0], bus.cin};
        bus.cout = bus.b[7];
      end
      core_pkg::ALU_PASSA: bus.res = bus.a;
      core_pkg::ALU_PASSB: bus.res = bus.b;
      core_pkg::ALU_SETB: bus.res = bus.b | bit_mask(bus.bsel);
      core_pkg::ALU_CLRB: bus.res = bus.b & ~bit_mask(bus.bsel);
      default:            bus.res = bus.b;
    endcase
  end

  // zero detect on the result
  assign bus.zero = (bus.res == 8'h00);
endmodule // alu_unit

//--- hdl/mcu_core.sv
`include "core_map.svh"
// Overview of operation
// - An instruction cycle is four system clocks and all work steps in it.
// - Ordinary instructions finish in one instruction cycle.
// - Jump, call, both exits and table read take two instruction cycles.
// - Writing the program counter low byte jumps and adds one cycle.
// - A skip test takes one cycle, or two when it skips.
// - A satisfied skip discards the next instruction, else it runs.
// - Logical operations set the zero flag on a zero result.
// - Add above 255 or subtract below 0 sets the carry flag.
// - Increment and decrement change the operand by one, to memory or acc.
// - Rotates move one bit; the carry forms pass the lost bit into carry.
// - Exit after a call resumes right after the call instruction.
// - A jump goes to its target and saves no return address.
// - Bit set and clear change only the addressed bit of a memory word.
// - Transfers exist from memory to acc, acc to memory, immediate to acc.
// - Table read fetches a program memory word into the data path.
// - One instruction powers down, another clears the watchdog.
module mcu_core #(
  parameter int DMEM_WORDS  = 128,
  parameter int STACK_DEPTH = 4
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [15:0] prog_data_i,
  input  wire logic        wake_i,
  output logic      [10:0] prog_addr_o,
  output logic      [7:0]  acc_o,
  output logic             carry_o,
  output logic             zero_o,
  output logic             halted_o,
  output logic             wdt_clear_o
);
  localparam int SPW = $clog2(STACK_DEPTH);
  localparam logic [SPW-1:0] SP_ONE = SPW'(1);

  // ****************************************
  // state
  // ****************************************
  core_pkg::state_t state, next_state;
  logic [1:0]   phase, next_phase;
  logic [10:0]  pc, next_pc;
  logic [10:0]  fetch, next_fetch;
  logic [7:0]   acc, next_acc;
  logic         carry, next_carry;
  logic         zero, next_zero;
  logic         wdt, next_wdt;
  logic [SPW-1:0] sp, next_sp;
  logic [7:0]   mem [DMEM_WORDS];
  logic [10:0]  stack [STACK_DEPTH];
  logic         mem_we;
  logic [6:0]   mem_wa;
  logic [7:0]   mem_wd;
  logic         stk_we;
  logic [10:0]  stk_wd;
  logic         wake_meta, wake_s;
  logic         exec_fire;
  logic         two_cycle;
  logic         skip_go;

  // ****************************************
  // instruction fields
  // ****************************************
  core_pkg::op_t op_f;
  logic          d_f;
  logic [2:0]    b_f;
  logic [6:0]    m_f;
  logic [7:0]    imm_f;
  logic [10:0]   tgt_f;
  logic [7:0]    mem_rd;

  assign op_f  = core_pkg::op_t'(prog_data_i[`F_OP_HI:`F_OP_LO]);
  assign d_f   = prog_data_i[`F_DEST];
  assign b_f   = prog_data_i[`F_BIT_HI:`F_BIT_LO];
  assign m_f   = prog_data_i[`F_MEM_HI:0];
  assign imm_f = prog_data_i[`F_IMM_HI:0];
  assign tgt_f = prog_data_i[`F_ADDR_HI:0];
  // low pc byte reads through the data map
  assign mem_rd = (m_f == `ADDR_PC_LO) ? pc[7:0] : mem[m_f];
  assign exec_fire = (state == core_pkg::ST_EXEC) && (phase == `PHASE_LAST);

  alu_if alu ();
  alu_unit u_alu (.bus(alu));

  // ****************************************
  // operand and function select
  // ****************************************
  always_comb begin
    alu.a    = acc;
    alu.b    = mem_rd;
    alu.cin  = carry;
    alu.bsel = b_f;
    alu.op   = core_pkg::ALU_PASSB;
    case (op_f)
      core_pkg::OP_ADD_M:  alu.op = core_pkg::ALU_ADD;
      core_pkg::OP_SUB_M:  alu.op = core_pkg::ALU_SUB;
      core_pkg::OP_ADD_X: begin
        alu.op = core_pkg::ALU_ADD;
        alu.b  = imm_f;
      end
      core_pkg::OP_SUB_X: begin
        alu.op = core_pkg::ALU_SUB;
        alu.b  = imm_f;
      end
      core_pkg::OP_AND_M:   alu.op = core_pkg::ALU_AND;
      core_pkg::OP_OR_M:    alu.op = core_pkg::ALU_OR;
      core_pkg::OP_XOR_M:   alu.op = core_pkg::ALU_XOR;
      core_pkg::OP_BITINV:  alu.op = core_pkg::ALU_INV;
      core_pkg::OP_INC,
      core_pkg::OP_SKINC:   alu.op = core_pkg::ALU_INC;
      core_pkg::OP_DEC,
      core_pkg::OP_SKDEC:   alu.op = core_pkg::ALU_DEC;
      core_pkg::OP_ROTR:    alu.op = core_pkg::ALU_ROR;
      core_pkg::OP_ROTL:    alu.op = core_pkg::ALU_ROL;
      core_pkg::OP_ROTRC:   alu.op = core_pkg::ALU_RORC;
      core_pkg::OP_ROTLC:   alu.op = core_pkg::ALU_ROLC;
      core_pkg::OP_XFER_MA: alu.op = core_pkg::ALU_PASSA;
      core_pkg::OP_XFER_X:  alu.b  = imm_f;
      core_pkg::OP_BITSET:  alu.op = core_pkg::ALU_SETB;
      core_pkg::OP_BITZERO: alu.op = core_pkg::ALU_CLRB;
      default:              alu.op = core_pkg::ALU_PASSB;
    endcase
  end

  // ****************************************
  // sequencer and execute
  // ****************************************
  always_comb begin
    logic wr;
    logic dst_mem;
    wr         = 1'b0;
    dst_mem    = d_f;
    two_cycle  = 1'b0;
    skip_go    = 1'b0;
    next_phase = phase + 2'h1;
    next_state = state;
    next_pc    = pc;
    next_fetch = fetch;
    next_acc   = acc;
    next_carry = carry;
    next_zero  = zero;
    next_sp    = sp;
    next_wdt   = 1'b0;
    mem_we     = 1'b0;
    mem_wa     = m_f;
    mem_wd     = alu.res;
    stk_we     = 1'b0;
    stk_wd     = pc + 11'h1;
    case (state)
      core_pkg::ST_EXEC: begin
        if (phase == `PHASE_LAST) begin
          next_pc = pc + 11'h1;
          case (op_f)
            core_pkg::OP_ADD_M, core_pkg::OP_SUB_M: begin
              wr         = 1'b1;
              next_carry = alu.cout;
              next_zero  = alu.zero;
            end
            core_pkg::OP_ADD_X, core_pkg::OP_SUB_X: begin
              wr         = 1'b1;
              dst_mem    = 1'b0;
              next_carry = alu.cout;
              next_zero  = alu.zero;
            end
            core_pkg::OP_AND_M, core_pkg::OP_OR_M, core_pkg::OP_XOR_M,
            core_pkg::OP_BITINV, core_pkg::OP_INC, core_pkg::OP_DEC: begin
              wr        = 1'b1;
              next_zero = alu.zero;
            end
            core_pkg::OP_ROTR, core_pkg::OP_ROTL: wr = 1'b1;
            core_pkg::OP_ROTRC, core_pkg::OP_ROTLC: begin
              wr         = 1'b1;
              next_carry = alu.cout;
            end
            core_pkg::OP_XFER_AM, core_pkg::OP_XFER_X: begin
              wr      = 1'b1;
              dst_mem = 1'b0;
            end
            core_pkg::OP_XFER_MA, core_pkg::OP_BITSET,
            core_pkg::OP_BITZERO: begin
              wr      = 1'b1;
              dst_mem = 1'b1;
            end
            core_pkg::OP_UJUMP: begin
              next_pc   = tgt_f;
              two_cycle = 1'b1;
            end
            core_pkg::OP_CALL: begin
              stk_we    = 1'b1;
              next_sp   = sp + SP_ONE;
              next_pc   = tgt_f;
              two_cycle = 1'b1;
            end
            core_pkg::OP_SUBEXIT, core_pkg::OP_INTEXIT: begin
              next_sp   = sp - SP_ONE;
              next_pc   = stack[sp - SP_ONE];
              two_cycle = 1'b1;
            end
            core_pkg::OP_SKZ:   skip_go = (mem_rd == 8'h00);
            core_pkg::OP_SKBZ:  skip_go = !mem_rd[b_f];
            core_pkg::OP_SKBNZ: skip_go = mem_rd[b_f];
            core_pkg::OP_SKINC, core_pkg::OP_SKDEC: begin
              wr      = 1'b1;
              skip_go = alu.zero;
            end
            core_pkg::OP_TABRD: next_state = core_pkg::ST_TBL;
            core_pkg::OP_PWRDN: next_state = core_pkg::ST_SLEEP;
            core_pkg::OP_WDTCLR: next_wdt = 1'b1;
            default: ;
          endcase
          // result store; a low pc byte target is a jump
          if (wr && dst_mem) begin
            if (m_f == `ADDR_PC_LO) begin
              next_pc   = {pc[10:8], alu.res};
              two_cycle = 1'b1;
            end else begin
              mem_we = 1'b1;
            end
          end else if (wr) begin
            next_acc = alu.res;
          end
          // satisfied skip steps over one word
          if (skip_go) begin
            next_pc   = pc + 11'h2;
            two_cycle = 1'b1;
          end
          if (two_cycle) begin
            next_state = core_pkg::ST_FLUSH;
          end
          next_fetch = next_pc;
          if (next_state == core_pkg::ST_TBL) begin
            next_fetch = {`TBL_PAGE, mem[`ADDR_TBLP]};
          end
        end
      end
      core_pkg::ST_FLUSH: begin
        if (phase == `PHASE_LAST) begin
          next_state = core_pkg::ST_EXEC;
        end
      end
      core_pkg::ST_TBL: begin
        if (phase == `PHASE_LAST) begin
          next_acc   = prog_data_i[7:0];
          mem_we     = 1'b1;
          mem_wa     = `ADDR_TBLH;
          mem_wd     = prog_data_i[15:8];
          next_fetch = pc;
          next_state = core_pkg::ST_EXEC;
        end
      end
      core_pkg::ST_SLEEP: begin
        if (wake_s) begin
          next_state = core_pkg::ST_EXEC;
        end
      end
      default: next_state = core_pkg::ST_EXEC;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= core_pkg::ST_EXEC;
      phase <= `RST_PHASE;
      pc    <= `RST_PC;
      fetch <= `RST_PC;
      acc   <= `RST_ACC;
      carry <= 1'b0;
      zero  <= 1'b0;
      wdt   <= 1'b0;
      sp    <= '0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      pc    <= next_pc;
      fetch <= next_fetch;
      acc   <= next_acc;
      carry <= next_carry;
      zero  <= next_zero;
      wdt   <= next_wdt;
      sp    <= next_sp;
    end
  end

  // wake pin synchroniser
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_meta <= 1'b0;
      wake_s    <= 1'b0;
    end else begin
      wake_meta <= wake_i;
      wake_s    <= wake_meta;
    end
  end

  // data memory and return stack, no reset
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (stk_we) begin
      stack[sp] <= stk_wd;
    end
  end

  assign prog_addr_o = fetch;
  assign acc_o       = acc;
  assign carry_o     = carry;
  assign zero_o      = zero;
  assign halted_o    = (state == core_pkg::ST_SLEEP);
  assign wdt_clear_o = wdt;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_phase_wrap: assert property (
    phase == `PHASE_LAST |=> phase == `RST_PHASE ##3 phase == `PHASE_LAST)
    else $error("instruction cycle is not four clocks");
  chk_one_cycle: assert property (
    exec_fire && !two_cycle && next_state == core_pkg::ST_EXEC
    |-> ##4 state == core_pkg::ST_EXEC && phase == `PHASE_LAST)
    else $error("single cycle instruction stretched");
  chk_two_cycle: assert property (
    exec_fire && two_cycle
    |-> ##4 state == core_pkg::ST_FLUSH ##4 exec_fire)
    else $error("two cycle instruction length wrong");
  chk_pcl_jump: assert property (
    exec_fire && mem_we == 1'b0 && m_f == `ADDR_PC_LO && d_f
    && op_f == core_pkg::OP_XFER_MA |=> pc == {$past(pc[10:8]), $past(acc)}
    && state == core_pkg::ST_FLUSH)
    else $error("low pc byte write did not jump");
  chk_skip_pc: assert property (
    exec_fire && skip_go |=> pc == $past(pc) + 11'h2
    && state == core_pkg::ST_FLUSH)
    else $error("skip did not step over one word");
  chk_no_skip: assert property (
    exec_fire && op_f == core_pkg::OP_SKZ && mem_rd != 8'h00
    |=> pc == $past(pc) + 11'h1 && state == core_pkg::ST_EXEC)
    else $error("unsatisfied skip took extra cycle");
  chk_zero_flag: assert property (
    exec_fire && op_f == core_pkg::OP_AND_M
    |=> zero == (($past(acc) & $past(mem_rd)) == 8'h00))
    else $error("zero flag wrong after logic op");
  chk_carry_add: assert property (
    exec_fire && op_f == core_pkg::OP_ADD_X
    |=> carry == ({1'b0, $past(acc)} + {1'b0, $past(imm_f)} > 9'h0ff))
    else $error("carry wrong after add");
  chk_call_ret: assert property (
    exec_fire && op_f == core_pkg::OP_CALL
    |=> stack[$past(sp)] == $past(pc) + 11'h1 && pc == $past(tgt_f))
    else $error("call saved wrong return address");
  chk_jmp_nosave: assert property (
    exec_fire && op_f == core_pkg::OP_UJUMP
    |=> pc == $past(tgt_f) && sp == $past(sp))
    else $error("jump target or stack wrong");
  chk_bit_only: assert property (
    exec_fire && op_f == core_pkg::OP_BITSET && m_f != `ADDR_PC_LO
    |=> ##1 mem[$past(m_f, 2)] == ($past(mem_rd, 2) | (8'h01 << $past(b_f, 2))))
    else $error("bit set touched other bits");
  chk_sleep_hold: assert property (
    state == core_pkg::ST_SLEEP && !wake_s |=> state == core_pkg::ST_SLEEP)
    else $error("left power down without wake");

  cov_call: cover property (exec_fire && op_f == core_pkg::OP_CALL);
  cov_skip: cover property (exec_fire && skip_go);
  cov_table: cover property (state == core_pkg::ST_TBL && phase == `PHASE_LAST);
  cov_wake: cover property (state == core_pkg::ST_SLEEP ##1 state == core_pkg::ST_EXEC);
endmodule // mcu_core

//--- sim/mcu_core_test.sv
module mcu_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // ports, program store and counters
  // ****************************************
  logic        clk_i       = 1'b0;
  logic        nrst_i      = 1'b0;
  logic [15:0] prog_data_i = 16'h0000;
  logic        wake_i      = 1'b0;
  logic [10:0] prog_addr_o;
  logic [7:0]  acc_o;
  logic        carry_o;
  logic        zero_o;
  logic        halted_o;
  logic        wdt_clear_o;
  logic [15:0] rom [0:2047];
  int          n_fail  = 0;
  int          n_tests = 0;
  int          n_wdt   = 0;

  // 20 mhz system clock
  always #25 clk_i = ~clk_i;

  mcu_core mcu_core_inst (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .prog_data_i (prog_data_i),
    .wake_i      (wake_i),
    .prog_addr_o (prog_addr_o),
    .acc_o       (acc_o),
    .carry_o     (carry_o),
    .zero_o      (zero_o),
    .halted_o    (halted_o),
    .wdt_clear_o (wdt_clear_o)
  );

  // program memory answers the fetch address just after each edge
  always @(posedge clk_i) begin
    #2 prog_data_i <= rom[prog_addr_o];
  end

  // count clocks with the watchdog clear pulse high
  always @(posedge clk_i) begin
    if (wdt_clear_o === 1'b1) n_wdt++;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] iw(input logic [4:0] op,
                                     input logic [10:0] f);
    return {op, f};
  endfunction

  task automatic end_of_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // reset for 16 clocks with an empty program
  task automatic start;
    @(posedge clk_i);
    #2 nrst_i = 1'b0;
    wake_i = 1'b0;
    for (int i = 0; i < 2048; i++) rom[i] = 16'h0000;
    repeat (16) @(posedge clk_i);
    n_wdt = 0;
    #2 nrst_i = 1'b1;
  endtask

  // count edges until the fetch address reaches stop
  task automatic run_to(input logic [10:0] stop, output int n);
    n = 0;
    while (prog_addr_o !== stop) begin
      @(posedge clk_i);
      #1 n++;
      if (n > 400) begin
        n_fail++;
        $display("[ERR] %0t fetch address never reached", $time);
        end_of_test;
      end
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_arith;
    int n;
    start;
    rom[0] = iw(core_pkg::OP_XFER_X, 11'h0f0);
    rom[1] = iw(core_pkg::OP_ADD_X, 11'h020);
    rom[2] = iw(core_pkg::OP_SUB_X, 11'h00f);
    rom[3] = iw(core_pkg::OP_SUB_X, 11'h002);
    run_to(11'h002, n);
    chk_n(n, 8);
    chk_v(acc_o, 8'h10);
    chk_b(carry_o, 1'b1);
    run_to(11'h003, n);
    chk_n(n, 4);
    chk_b(carry_o, 1'b0);
    run_to(11'h004, n);
    chk_v(acc_o, 8'hff);
    chk_b(carry_o, 1'b1);
  endtask

  task automatic t_logic;
    int n;
    start;
    rom[0] = iw(core_pkg::OP_XFER_X, 11'h05a);
    rom[1] = iw(core_pkg::OP_XFER_MA, 11'h00a);
    rom[2] = iw(core_pkg::OP_BITSET, 11'h00a);
    rom[3] = iw(core_pkg::OP_BITZERO, 11'h30a);
    rom[4] = iw(core_pkg::OP_XFER_X, 11'h01b);
    rom[5] = iw(core_pkg::OP_XOR_M, 11'h00a);
    rom[6] = iw(core_pkg::OP_OR_M, 11'h00a);
    rom[7] = iw(core_pkg::OP_AND_M, 11'h00a);
    run_to(11'h006, n);
    chk_v(acc_o, 8'h00);
    chk_b(zero_o, 1'b1);
    run_to(11'h007, n);
    chk_v(acc_o, 8'h1b);
    chk_b(zero_o, 1'b0);
    run_to(11'h008, n);
    chk_v(acc_o, 8'h1b);
    chk_b(zero_o, 1'b0);
  endtask

  task automatic t_rotate;
    int n;
    start;
    rom[0] = iw(core_pkg::OP_XFER_X, 11'h081);
    rom[1] = iw(core_pkg::OP_XFER_MA, 11'h014);
    rom[2] = iw(core_pkg::OP_ROTLC, 11'h414);
    rom[3] = iw(core_pkg::OP_ROTRC, 11'h414);
    rom[4] = iw(core_pkg::OP_DEC, 11'h414);
    rom[5] = iw(core_pkg::OP_ROTL, 11'h014);
    rom[6] = iw(core_pkg::OP_INC, 11'h014);
    run_to(11'h003, n);
    chk_b(carry_o, 1'b1);
    run_to(11'h006, n);
    chk_v(acc_o, 8'h01);
    chk_b(carry_o, 1'b0);
    run_to(11'h007, n);
    chk_v(acc_o, 8'h81);
  endtask

  task automatic t_branch;
    int n;
    start;
    rom[0]  = iw(core_pkg::OP_UJUMP, 11'h004);
    rom[1]  = iw(core_pkg::OP_XFER_X, 11'h0ee);
    rom[4]  = iw(core_pkg::OP_CALL, 11'h008);
    rom[5]  = iw(core_pkg::OP_CALL, 11'h00a);
    rom[8]  = iw(core_pkg::OP_XFER_X, 11'h033);
    rom[9]  = iw(core_pkg::OP_SUBEXIT, 11'h000);
    rom[10] = iw(core_pkg::OP_INTEXIT, 11'h000);
    run_to(11'h007, n);
    chk_n(n, 48);
    chk_v(acc_o, 8'h33);
  endtask

  task automatic t_skip;
    int n;
    start;
    rom[0] = iw(core_pkg::OP_XFER_X, 11'h000);
    rom[1] = iw(core_pkg::OP_XFER_MA, 11'h01e);
    rom[2] = iw(core_pkg::OP_SKZ, 11'h01e);
    rom[3] = iw(core_pkg::OP_XFER_X, 11'h011);
    rom[4] = iw(core_pkg::OP_SKBNZ, 11'h01e);
    rom[5] = iw(core_pkg::OP_XFER_X, 11'h022);
    run_to(11'h007, n);
    chk_n(n, 28);
    chk_v(acc_o, 8'h22);
  endtask

  task automatic t_pcl;
    int n;
    start;
    rom[0] = iw(core_pkg::OP_XFER_X, 11'h005);
    rom[1] = iw(core_pkg::OP_XFER_MA, 11'h402);
    rom[2] = iw(core_pkg::OP_XFER_X, 11'h0ff);
    run_to(11'h006, n);
    chk_n(n, 16);
    chk_v(acc_o, 8'h05);
  endtask

  task automatic t_table;
    int n;
    start;
    rom[0] = iw(core_pkg::OP_XFER_X, 11'h009);
    rom[1] = iw(core_pkg::OP_XFER_MA, 11'h003);
    rom[2] = iw(core_pkg::OP_TABRD, 11'h000);
    rom[4] = iw(core_pkg::OP_XFER_AM, 11'h004);
    rom[11'h709] = 16'habcd;
    run_to(11'h004, n);
    chk_n(n, 20);
    chk_v(acc_o, 8'hcd);
    run_to(11'h005, n);
    chk_v(acc_o, 8'hab);
  endtask

  task automatic t_power;
    int n;
    start;
    rom[0] = iw(core_pkg::OP_WDTCLR, 11'h000);
    rom[1] = iw(core_pkg::OP_PWRDN, 11'h000);
    rom[2] = iw(core_pkg::OP_XFER_X, 11'h044);
    run_to(11'h002, n);
    repeat (20) @(posedge clk_i);
    #1 chk_b(halted_o, 1'b1);
    chk_v(acc_o, 8'h00);
    chk_n(n_wdt, 1);
    #1 wake_i = 1'b1;
    for (n = 0; n < 10 && halted_o !== 1'b0; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk_b(halted_o, 1'b0);
    @(posedge clk_i);
    #2 wake_i = 1'b0;
    run_to(11'h004, n);
    chk_v(acc_o, 8'h44);
  endtask

  // main sequence
  initial begin
    t_arith;
    t_logic;
    t_rotate;
    t_branch;
    t_skip;
    t_pcl;
    t_table;
    t_power;
    end_of_test;
  end
endmodule // mcu_core_test
